// file: hdl/wwd_pkg.sv
package wwd_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_RELOAD = 8'h08;
	localparam logic [7:0] OFF_WINDOW = 8'h0C;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_MASK = 8'h18;
	// control register fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_CLKSEL_BIT = 1;
	localparam int CTRL_DIVSEL_BIT = 2;
	// command register fields, write-only strobes
	localparam int CMD_SERVICE_BIT = 0;
	localparam int CMD_DISABLE_BIT = 1;
	localparam int CMD_ENABLE_BIT = 2;
	// status and mask fields
	localparam int ST_OVF_BIT = 0;
	localparam int ST_WIN_BIT = 1;
	localparam int ST_W = 2;
	// prescaler ratios
	localparam int PRE_W = 14;
	localparam logic [13:0] DIV_LONG_LAST = 14'h3FFF;
	localparam logic [13:0] DIV_SHORT_LAST = 14'h00FF;
	localparam int DIV_SHORT = 256;
	// power-up interval on the wake-up clock
	localparam int TIMEOUT_DEF_US = 130000;
	localparam int WAKEUP_FREQ_KHZ = 500;
	localparam int TIMEOUT_DEF_TICKS = (TIMEOUT_DEF_US * WAKEUP_FREQ_KHZ / 1000 + DIV_SHORT / 2)
		/ DIV_SHORT;
	localparam logic [15:0] RELOAD_DEF = 16'(32'd65536 - 32'(TIMEOUT_DEF_TICKS));
	localparam logic [15:0] WINDOW_DEF = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic CLKSEL_SYS = 1'b0;
	localparam logic CLKSEL_WAKEUP = 1'b1;
	localparam logic DIVSEL_LONG = 1'b0;
	localparam logic DIVSEL_SHORT = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hdl/wwd_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module wwd_prescaler (
	input wire logic clk_i,
	input wire logic rst_i,
	wwd_tick_if.pre tk
);
	typedef struct packed {
		logic [wwd_pkg::PRE_W-1:0] cnt;
		logic tick;
	} wwd_pre_state_t;

	wwd_pre_state_t s_r;
	wwd_pre_state_t s_nxt;
	logic [wwd_pkg::PRE_W-1:0] last;

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		last = tk.div_short ? wwd_pkg::DIV_SHORT_LAST : wwd_pkg::DIV_LONG_LAST;
		if (tk.clear) begin
			s_nxt.cnt = '0;
		end else if (tk.src_tick) begin
			if (s_r.cnt >= last) begin
				s_nxt.cnt = '0;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tk.tick = s_r.tick;
endmodule
`default_nettype wire

// file: hdl/wwd_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface wwd_tick_if;
	logic src_tick;
	logic div_short;
	logic clear;
	logic tick;
	modport ctl (output src_tick, output div_short, output clear, input tick);
	modport pre (input src_tick, input div_short, input clear, output tick);
endinterface
`default_nettype wire

// file: hdl/wwd_top.sv
// Overview of operation
// - watchdog runs after every application reset
// - disable and enable commands accepted anytime
// - unserviced overflow raises reset request
// - service below window boundary while enabled raises reset
// - 16-bit counter, system or wake-up clock
// - prescaler divides by 16384 or 256
// - service at or above window boundary loads counter from reload value
// - power-up default interval 0.13 s
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wwd_top (
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic WAKEUP_CLK_I,
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	output logic RESET_REQ_O,
	output logic IRQ_O
);
	typedef struct packed {
		logic en;
		logic clk_sel;
		logic div_sel;
		logic [15:0] reload;
		logic [15:0] window;
		logic [15:0] cnt;
		logic [wwd_pkg::ST_W-1:0] st;
		logic [wwd_pkg::ST_W-1:0] mask;
		logic irq;
		logic rst_req;
		logic wu_prev;
		logic pre_clear;
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} wwd_state_t;

	wwd_state_t s_r;
	wwd_state_t s_nxt;
	wwd_tick_if tk();

	wwd_prescaler u_pre (
		.clk_i(CLOCK_I),
		.rst_i(SYS_RST_I),
		.tk(tk.pre)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic do_write;
	logic do_read;
	logic wr_ok;
	logic service;
	logic [31:0] ctrl_word;
	logic [31:0] wmerged;
	logic [wwd_pkg::ST_W-1:0] st_set;
	logic [wwd_pkg::ST_W-1:0] st_clr;

	// wake-up clock is sampled as a plain input; its rising edge is a count source
	assign tk.src_tick = (s_r.clk_sel == wwd_pkg::CLKSEL_SYS) ? 1'b1
		: (WAKEUP_CLK_I & ~s_r.wu_prev);
	assign tk.div_short = (s_r.div_sel == wwd_pkg::DIVSEL_SHORT);
	assign tk.clear = s_r.pre_clear;

	always_comb begin
		s_nxt = s_r;
		s_nxt.wu_prev = WAKEUP_CLK_I;
		s_nxt.rst_req = 1'b0;
		s_nxt.pre_clear = 1'b0;
		st_set = '0;
		st_clr = '0;
		service = 1'b0;
		wr_ok = 1'b1;
		ctrl_word = '0;
		ctrl_word[wwd_pkg::CTRL_EN_BIT] = s_r.en;
		ctrl_word[wwd_pkg::CTRL_CLKSEL_BIT] = s_r.clk_sel;
		ctrl_word[wwd_pkg::CTRL_DIVSEL_BIT] = s_r.div_sel;
		wmerged = '0;

		// write channel: address and data taken in either order
		if (S_AXI_AWVALID_I && s_r.awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.awready = 1'b0;
			s_nxt.awaddr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && s_r.wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.wready = 1'b0;
			s_nxt.wdata = S_AXI_WDATA_I;
			s_nxt.wstrb = S_AXI_WSTRB_I;
		end
		do_write = s_r.aw_have && s_r.w_have && !s_r.bvalid;
		if (do_write) begin
			unique case (s_r.awaddr)
				wwd_pkg::OFF_CTRL: begin
					wmerged = merge(ctrl_word, s_r.wdata, s_r.wstrb);
					s_nxt.clk_sel = wmerged[wwd_pkg::CTRL_CLKSEL_BIT];
					s_nxt.div_sel = wmerged[wwd_pkg::CTRL_DIVSEL_BIT];
				end
				wwd_pkg::OFF_CMD: begin
					if (s_r.wstrb[0]) begin
						service = s_r.wdata[wwd_pkg::CMD_SERVICE_BIT];
						if (s_r.wdata[wwd_pkg::CMD_DISABLE_BIT]) begin
							s_nxt.en = 1'b0;
						end
						if (s_r.wdata[wwd_pkg::CMD_ENABLE_BIT]) begin
							s_nxt.en = 1'b1;
						end
					end
				end
				wwd_pkg::OFF_RELOAD: begin
					wmerged = merge({16'h0000, s_r.reload}, s_r.wdata, s_r.wstrb);
					s_nxt.reload = wmerged[15:0];
				end
				wwd_pkg::OFF_WINDOW: begin
					wmerged = merge({16'h0000, s_r.window}, s_r.wdata, s_r.wstrb);
					s_nxt.window = wmerged[15:0];
				end
				wwd_pkg::OFF_STATUS: begin
					if (s_r.wstrb[0]) begin
						st_clr = s_r.wdata[wwd_pkg::ST_W-1:0];
					end
				end
				wwd_pkg::OFF_MASK: begin
					if (s_r.wstrb[0]) begin
						s_nxt.mask = s_r.wdata[wwd_pkg::ST_W-1:0];
					end
				end
				default: begin
					wr_ok = 1'b0;
				end
			endcase
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = wr_ok ? wwd_pkg::RESP_OKAY : wwd_pkg::RESP_SLVERR;
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
		end
		if (s_r.bvalid && S_AXI_BREADY_I) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
		end

		// read channel: data one cycle after the address is taken
		do_read = S_AXI_ARVALID_I && s_r.arready;
		if (do_read) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = wwd_pkg::RESP_OKAY;
			unique case (S_AXI_ARADDR_I)
				wwd_pkg::OFF_CTRL: s_nxt.rdata = ctrl_word;
				wwd_pkg::OFF_CMD: s_nxt.rdata = '0;
				wwd_pkg::OFF_RELOAD: s_nxt.rdata = {16'h0000, s_r.reload};
				wwd_pkg::OFF_WINDOW: s_nxt.rdata = {16'h0000, s_r.window};
				wwd_pkg::OFF_COUNT: s_nxt.rdata = {16'h0000, s_r.cnt};
				wwd_pkg::OFF_STATUS: s_nxt.rdata = {30'h0, s_r.st};
				wwd_pkg::OFF_MASK: s_nxt.rdata = {30'h0, s_r.mask};
				default: begin
					s_nxt.rdata = '0;
					s_nxt.rresp = wwd_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (s_r.rvalid && S_AXI_RREADY_I) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end

		// counter; a service wins over a tick in the same cycle
		if (service) begin
			if (s_r.en && (s_r.cnt < s_r.window)) begin
				st_set[wwd_pkg::ST_WIN_BIT] = 1'b1;
				s_nxt.rst_req = 1'b1;
			end else begin
				s_nxt.cnt = s_r.reload;
				s_nxt.pre_clear = 1'b1;
			end
		end else if (s_r.en && tk.tick) begin
			if (s_r.cnt == wwd_pkg::CNT_MAX) begin
				st_set[wwd_pkg::ST_OVF_BIT] = 1'b1;
				s_nxt.rst_req = 1'b1;
				s_nxt.cnt = s_r.reload;
			end else begin
				s_nxt.cnt = s_r.cnt + 1'b1;
			end
		end

		// set wins over a same-cycle write-one clear
		s_nxt.st = (s_r.st & ~st_clr) | st_set;
		s_nxt.irq = |(s_nxt.st & s_nxt.mask);
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			s_r <= '0;
			s_r.en <= 1'b1;
			s_r.clk_sel <= wwd_pkg::CLKSEL_WAKEUP;
			s_r.div_sel <= wwd_pkg::DIVSEL_SHORT;
			s_r.reload <= wwd_pkg::RELOAD_DEF;
			s_r.cnt <= wwd_pkg::RELOAD_DEF;
			s_r.window <= wwd_pkg::WINDOW_DEF;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign S_AXI_AWREADY_O = s_r.awready;
	assign S_AXI_WREADY_O = s_r.wready;
	assign S_AXI_BRESP_O = s_r.bresp;
	assign S_AXI_BVALID_O = s_r.bvalid;
	assign S_AXI_ARREADY_O = s_r.arready;
	assign S_AXI_RDATA_O = s_r.rdata;
	assign S_AXI_RRESP_O = s_r.rresp;
	assign S_AXI_RVALID_O = s_r.rvalid;
	assign RESET_REQ_O = s_r.rst_req;
	assign IRQ_O = s_r.irq;
endmodule
`default_nettype wire

// file: verification/wwd_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module wwd_assertions (
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	input wire logic S_AXI_ARREADY_O,
	input wire logic S_AXI_AWVALID_I,
	input wire logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input wire logic S_AXI_WREADY_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic [1:0] S_AXI_RRESP_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic RESET_REQ_O,
	input wire logic IRQ_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	sequence s_wr_taken;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence s_rd_taken;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	property p_req_pulse;
		RESET_REQ_O |=> !RESET_REQ_O;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("reset request too long");
	property p_rst_quiet;
		$fell(SYS_RST_I) |-> !RESET_REQ_O && !IRQ_O && !S_AXI_BVALID_O && !S_AXI_RVALID_O;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
	property p_b_answer;
		s_wr_taken |-> ##2 S_AXI_BVALID_O;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write response late");
	property p_r_answer;
		s_rd_taken |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read response late");
	property p_r_hold;
		S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold;
		S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_unmapped;
		s_rd_taken and (S_AXI_ARADDR_I > wwd_pkg::OFF_MASK) |=> S_AXI_RRESP_O == wwd_pkg::RESP_SLVERR;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_irq_steady;
		!S_AXI_BVALID_O ##1 !S_AXI_BVALID_O && !RESET_REQ_O |-> $stable(IRQ_O);
	endproperty
	a_irq_steady: assert property (p_irq_steady) else $error("irq moved without cause");
endmodule
`default_nettype wire

// file: verification/wwd_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module wwd_tb_top;
	logic clk, rst, wk, awv, wv, br, arv, rr, awr, wr_, bv, arr, rv, req, irq;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, d;
	logic [1:0] bresp, rresp;
	int err_count = 0;
	int num_checks = 0;
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	wwd_wake_osc osc (.clk_i(clk), .wake_o(wk));
	wwd_top uut (.CLOCK_I(clk), .SYS_RST_I(rst), .WAKEUP_CLK_I(wk), .S_AXI_AWADDR_I(awa),
		.S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
		.S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
		.S_AXI_RREADY_I(rr), .RESET_REQ_O(req), .IRQ_O(irq));
	task chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	logic [1:0] wresp;
	logic [1:0] rsp;
	// lag holds bready or rready low for a while, so the answer has to stand
	task wr(input logic [7:0] a, input logic [31:0] v, input int lag = 0);
		int k;
		k = 0;
		@(posedge clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= (lag == 0);
		do begin
			@(posedge clk);
			if (awr && awv) begin
				awv <= 1'b0;
			end
			if (wr_ && wv) begin
				wv <= 1'b0;
			end
			if (k >= lag && !br) begin
				br <= 1'b1;
			end
			k++;
		end while (!(bv && br));
		wresp = bresp;
		br <= 1'b0;
	endtask
	task rdw(input logic [7:0] a, input int lag = 0);
		int k;
		k = 0;
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= (lag == 0);
		do begin
			@(posedge clk);
			if (arr && arv) begin
				arv <= 1'b0;
			end
			if (k >= lag && !rr) begin
				rr <= 1'b1;
			end
			k++;
		end while (!(rv && rr));
		d = rd;
		rsp = rresp;
		rr <= 1'b0;
	endtask
	task wait_req(output int n);
		n = 0;
		while (req !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task t_defaults;
		rdw(8'h00);
		chk(d, 32'h7, "ctrl");
		rdw(8'h10, 2);
		chk(d, 32'hFF02, "count");
		rdw(8'h40);
		chk({d[1:0], rsp}, 4'h2, "unmapped read");
		wr(8'h40, 32'h0000FFFF, 3);
		chk(wresp, 2'h2, "unmapped write");
		// one wake-up prescaler period is about 1024 cycles here
		repeat (1500) @(posedge clk);
		rdw(8'h10);
		chk(d, 32'hFF03, "wake-up tick");
	endtask
	task t_overflow;
		int n;
		wr(8'h00, 32'h4);
		chk(wresp, 2'h0, "write okay");
		wr(8'h08, 32'hFFFE);
		wr(8'h04, 32'h1);
		rdw(8'h10);
		chk(d, 32'hFFFE, "reload");
		wait_req(n);
		chk(n > 400 && n < 600, 1, "overflow time");
		rdw(8'h14);
		chk(d, 32'h1, "ovf status");
		wr(8'h18, 32'h1);
		chk(irq, 1, "irq");
		wr(8'h14, 32'h1);
		chk(irq, 0, "irq clr");
	endtask
	task t_window;
		int n;
		wr(8'h0C, 32'hFFFF);
		wr(8'h04, 32'h1);
		wait_req(n);
		chk(n < 2, 1, "early request");
		rdw(8'h14);
		chk(d, 32'h2, "early");
		wr(8'h14, 32'h3);
		wr(8'h08, 32'h1234);
		wr(8'h0C, 32'hFFFE);
		wr(8'h04, 32'h1);
		rdw(8'h10, 2);
		chk(d, 32'h1234, "accepted");
		rdw(8'h14);
		chk(d, 32'h0, "no early");
	endtask
	task t_disable;
		logic [31:0] c;
		wr(8'h04, 32'h2);
		rdw(8'h00);
		chk(d, 32'h4, "off");
		rdw(8'h10);
		c = d;
		repeat (600) @(posedge clk);
		rdw(8'h10);
		chk(d, c, "frozen");
		wr(8'h04, 32'h4);
		rdw(8'h00);
		chk(d, 32'h5, "on");
	endtask
	// a disabled watchdog must come back running from a mid-run reset
	task t_reset;
		wr(8'h04, 32'h2);
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdw(8'h00);
		chk(d, 32'h7, "ctrl after reset");
		rdw(8'h10);
		chk(d, 32'hFF02, "count after reset");
	endtask
	initial begin
		rst = 1'b1;
		awv = 1'b0;
		wv = 1'b0;
		br = 1'b0;
		arv = 1'b0;
		rr = 1'b0;
		awa = '0;
		ara = '0;
		wd = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_defaults;
		t_overflow;
		t_window;
		t_disable;
		t_reset;
		end_sim;
	end
	initial begin
		#200000;
		err_count++;
		end_sim;
	end
endmodule
bind wwd_top wwd_assertions chk_u (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
	.S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
	.S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
	.S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
	.S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_RDATA_O(S_AXI_RDATA_O),
	.S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
	.S_AXI_RREADY_I(S_AXI_RREADY_I), .RESET_REQ_O(RESET_REQ_O), .IRQ_O(IRQ_O));
`default_nettype wire

// file: verification/wwd_wake_osc.sv
`timescale 1ns/10ps
`default_nettype none
module wwd_wake_osc (
	input wire logic clk_i,
	output logic wake_o
);
	logic [0:0] div_r = 1'b0;
	initial wake_o = 1'b0;
	// free-running slow source, unrelated to bus traffic
	always @(posedge clk_i) begin
		div_r <= div_r + 1'b1;
		if (div_r == 1'b1) wake_o <= ~wake_o;
	end
endmodule
`default_nettype wire
